/* File: cpu_sub_trap_pkg.sv */
// Overview of operation
// [RULE1] Byte subtract takes memory from A or B and writes back to it.
// [RULE2] Negative flag copies result bit 7, or bit 15 for the word subtract.
// [RULE3] Byte overflow: operand signs differ and result sign leaves accumulator sign.
// [RULE4] Byte carry is the borrow out of bit 7 from the three sign bits.
// [RULE5] Byte opcodes 80/90/B0/A0 and C0/D0/F0/E0, prefix 18 for Y, with dummy reads.
// [RULE6] Word subtract reads high byte then low byte and updates the double accumulator.
// [RULE7] Carry always means borrow in every subtract.
// [RULE8] Word overflow and borrow are judged from bit 15 of operands and result.
// [RULE9] Word opcodes 83/93/B3/A3 and 18 A3, ending with a dummy FFFF read.
// [RULE10] Trap return address points past the trap opcode.
// [RULE11] Trap pushes PC lo/hi, Y lo/hi, X lo/hi, A, B, then condition byte.
// [RULE12] Stack pointer drops by one after each of the nine pushed bytes.
// [RULE13] After stacking, only the interrupt mask bit is set.
// [RULE14] PC loads from the trap vector, high then low, and fetching resumes there.
// [RULE15] Trap is never blocked by the interrupt mask.
// [RULE16] Opcode 3F takes 14 cycles including dummy, repeat and vector reads.
// [RULE17] Indexed address is index plus the unsigned offset byte.
package cpu_sub_trap_pkg;
  localparam logic [7:0] OPC_PREFIX_Y = 8'h18;
  localparam logic [7:0] OPC_TRAP = 8'h3F;
  localparam logic [7:0] OPC_SUBFIRST_IDX = 8'hA0;
  localparam logic [7:0] OPC_SUBSECOND_IDX = 8'hE0;
  localparam logic [7:0] OPC_SUBWORD_IDX = 8'hA3;
  localparam logic [3:0] OPC_BYTE_LO = 4'h0;
  localparam logic [3:0] OPC_WORD_LO = 4'h3;
  localparam logic [1:0] OPC_WORD_HI = 2'h2;
  localparam logic [1:0] MODE_IMMED = 2'h0;
  localparam logic [1:0] MODE_DIR = 2'h1;
  localparam logic [1:0] MODE_IDX = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  // Vector location is arbitrary
  localparam logic [15:0] TRAP_VECTOR = 16'hFFF0;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] FLAGS_RESET = 8'h10;
  localparam int FLAG_I = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [3:0] PUSH_LAST = 4'h8;
  typedef enum logic [3:0] {
    ST_FETCH, ST_PREOP, ST_ARG1, ST_ARG2, ST_IDXDUM, ST_OPHI, ST_OPLO, ST_TAILDUM,
    ST_TRAPDUM, ST_PUSH, ST_TRAPRPT, ST_VECHI, ST_VECLO
  } state_t;
endpackage

/* File: cpu_subtract_and_soft_trap.sv */
`timescale 1ns/100ps
module cpu_subtract_and_soft_trap import cpu_sub_trap_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic presetEn,
  input wire logic [15:0] presetPc,
  input wire logic [15:0] presetX,
  input wire logic [15:0] presetY,
  input wire logic [15:0] presetSp,
  input wire logic [7:0] presetA,
  input wire logic [7:0] presetB,
  input wire logic [7:0] presetFlags,
  input wire logic [7:0] busDataIn,
  output logic [15:0] busAddr,
  output logic [7:0] busDataOut,
  output logic busRw,
  output logic opFetch,
  output logic [7:0] firstAccumulator,
  output logic [7:0] secondAccumulator,
  output logic [15:0] indexX,
  output logic [15:0] indexY,
  output logic [15:0] stackPtr,
  output logic [15:0] progCnt,
  output logic [7:0] conditionCodeByte
);
  // ****************************************
  // State
  // ****************************************
  state_t state_r, state_nxt;
  logic [15:0] pc_r, pc_nxt, x_r, x_nxt, y_r, y_nxt, sp_r, sp_nxt, ea_r, ea_nxt;
  logic [7:0] a_r, a_nxt, b_r, b_nxt, flags_r, flags_nxt, opc_r, opc_nxt, opHi_r, opHi_nxt, opLo_r, opLo_nxt;
  logic useY_r, useY_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic execByte, execWord, isWord;
  logic [7:0] selAcc, diffByte, pushByte;
  logic [15:0] double_accumulator, operWord, diffWord;

  assign isWord = (opc_r[7:6] == OPC_WORD_HI) && (opc_r[3:0] == OPC_WORD_LO);
  assign selAcc = opc_r[6] ? b_r : a_r;
  assign diffByte = selAcc - busDataIn; // RULE1
  assign double_accumulator = {a_r, b_r};
  assign operWord = {opHi_r, opLo_r};
  assign diffWord = double_accumulator - operWord; // RULE6

  always_comb begin
    unique case (cnt_r) // RULE11
      4'h0: pushByte = pc_r[7:0];
      4'h1: pushByte = pc_r[15:8];
      4'h2: pushByte = y_r[7:0];
      4'h3: pushByte = y_r[15:8];
      4'h4: pushByte = x_r[7:0];
      4'h5: pushByte = x_r[15:8];
      4'h6: pushByte = a_r;
      4'h7: pushByte = b_r;
      default: pushByte = flags_r;
    endcase
  end

  // ****************************************
  // Sequencer and execute
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    x_nxt = x_r;
    y_nxt = y_r;
    sp_nxt = sp_r;
    ea_nxt = ea_r;
    a_nxt = a_r;
    b_nxt = b_r;
    flags_nxt = flags_r;
    opc_nxt = opc_r;
    opHi_nxt = opHi_r;
    opLo_nxt = opLo_r;
    useY_nxt = useY_r;
    cnt_nxt = cnt_r;
    busAddr = pc_r;
    busRw = 1'b1;
    busDataOut = 8'h00;
    execByte = 1'b0;
    execWord = 1'b0;
    unique case (state_r)
      ST_FETCH: begin
        pc_nxt = pc_r + 16'h0001; // RULE10
        opc_nxt = busDataIn;
        useY_nxt = 1'b0;
        if (busDataIn == OPC_PREFIX_Y) begin // RULE5 RULE9
          useY_nxt = 1'b1;
          state_nxt = ST_PREOP;
        end else if (busDataIn == OPC_TRAP) begin
          // The mask bit is not consulted here
          state_nxt = ST_TRAPDUM; // RULE15
        end else if ((busDataIn[7] && busDataIn[3:0] == OPC_BYTE_LO) ||
                     (busDataIn[7:6] == OPC_WORD_HI && busDataIn[3:0] == OPC_WORD_LO)) begin
          state_nxt = ST_ARG1; // RULE5 RULE9
        end
      end
      ST_PREOP: begin
        pc_nxt = pc_r + 16'h0001;
        opc_nxt = busDataIn;
        // Unsupported prefixed opcodes fall back to fetch
        if (busDataIn == OPC_SUBFIRST_IDX || busDataIn == OPC_SUBSECOND_IDX || busDataIn == OPC_SUBWORD_IDX) begin
          state_nxt = ST_ARG1;
        end else begin
          state_nxt = ST_FETCH;
        end
      end
      ST_ARG1: begin
        pc_nxt = pc_r + 16'h0001;
        unique case (opc_r[5:4])
          MODE_IMMED: begin
            if (isWord) begin
              opHi_nxt = busDataIn;
              state_nxt = ST_ARG2;
            end else begin
              execByte = 1'b1;
              state_nxt = ST_FETCH;
            end
          end
          MODE_DIR: begin
            ea_nxt = {8'h00, busDataIn};
            state_nxt = ST_OPHI;
          end
          MODE_IDX: begin
            ea_nxt = (useY_r ? y_r : x_r) + {8'h00, busDataIn}; // RULE17
            state_nxt = ST_IDXDUM;
          end
          MODE_EXT: begin
            ea_nxt = {busDataIn, 8'h00};
            state_nxt = ST_ARG2;
          end
        endcase
      end
      ST_ARG2: begin
        pc_nxt = pc_r + 16'h0001;
        if (opc_r[5:4] == MODE_IMMED) begin
          opLo_nxt = busDataIn;
          state_nxt = ST_TAILDUM;
        end else begin
          ea_nxt = {ea_r[15:8], busDataIn};
          state_nxt = ST_OPHI;
        end
      end
      ST_IDXDUM: begin
        busAddr = DUMMY_ADDR; // RULE5
        state_nxt = ST_OPHI;
      end
      ST_OPHI: begin
        busAddr = ea_r;
        if (isWord) begin
          opHi_nxt = busDataIn; // RULE6
          state_nxt = ST_OPLO;
        end else begin
          execByte = 1'b1;
          state_nxt = ST_FETCH;
        end
      end
      ST_OPLO: begin
        busAddr = ea_r + 16'h0001;
        opLo_nxt = busDataIn;
        state_nxt = ST_TAILDUM;
      end
      ST_TAILDUM: begin
        busAddr = DUMMY_ADDR; // RULE9
        execWord = 1'b1;
        state_nxt = ST_FETCH;
      end
      ST_TRAPDUM: begin
        cnt_nxt = 4'h0;
        state_nxt = ST_PUSH;
      end
      ST_PUSH: begin
        busAddr = sp_r;
        busRw = 1'b0;
        busDataOut = pushByte; // RULE11
        sp_nxt = sp_r - 16'h0001; // RULE12
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == PUSH_LAST) begin
          state_nxt = ST_TRAPRPT;
        end
      end
      ST_TRAPRPT: begin
        busAddr = sp_r + 16'h0001; // RULE16
        flags_nxt[FLAG_I] = 1'b1; // RULE13
        state_nxt = ST_VECHI;
      end
      ST_VECHI: begin
        busAddr = TRAP_VECTOR;
        pc_nxt = {busDataIn, pc_r[7:0]}; // RULE14
        state_nxt = ST_VECLO;
      end
      ST_VECLO: begin
        busAddr = TRAP_VECTOR + 16'h0001;
        pc_nxt = {pc_r[15:8], busDataIn}; // RULE14
        state_nxt = ST_FETCH;
      end
    endcase
    if (execByte) begin
      if (opc_r[6]) begin
        b_nxt = diffByte; // RULE1
      end else begin
        a_nxt = diffByte; // RULE1
      end
      flags_nxt[FLAG_N] = diffByte[7]; // RULE2
      flags_nxt[FLAG_Z] = (diffByte == 8'h00);
      flags_nxt[FLAG_V] = (selAcc[7] & ~busDataIn[7] & ~diffByte[7]) |
                          (~selAcc[7] & busDataIn[7] & diffByte[7]); // RULE3
      flags_nxt[FLAG_C] = (~selAcc[7] & busDataIn[7]) | (busDataIn[7] & diffByte[7]) |
                          (diffByte[7] & ~selAcc[7]); // RULE4 RULE7
    end
    if (execWord) begin
      a_nxt = diffWord[15:8]; // RULE6
      b_nxt = diffWord[7:0];
      flags_nxt[FLAG_N] = diffWord[15]; // RULE2
      flags_nxt[FLAG_Z] = (diffWord == 16'h0000);
      flags_nxt[FLAG_V] = (double_accumulator[15] & ~operWord[15] & ~diffWord[15]) |
                          (~double_accumulator[15] & operWord[15] & diffWord[15]); // RULE8
      flags_nxt[FLAG_C] = (~double_accumulator[15] & operWord[15]) | (operWord[15] & diffWord[15]) |
                          (diffWord[15] & ~double_accumulator[15]); // RULE8 RULE7
    end
    // Preset overrides the state and every model register so a test can seed the programmer's model
    if (presetEn) begin
      state_nxt = ST_FETCH;
      pc_nxt = presetPc;
      x_nxt = presetX;
      y_nxt = presetY;
      sp_nxt = presetSp;
      a_nxt = presetA;
      b_nxt = presetB;
      flags_nxt = presetFlags;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_FETCH;
      pc_r <= PC_RESET;
      x_r <= 16'h0000;
      y_r <= 16'h0000;
      sp_r <= SP_RESET;
      ea_r <= 16'h0000;
      a_r <= 8'h00;
      b_r <= 8'h00;
      flags_r <= FLAGS_RESET;
      opc_r <= 8'h00;
      opHi_r <= 8'h00;
      opLo_r <= 8'h00;
      useY_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      sp_r <= sp_nxt;
      ea_r <= ea_nxt;
      a_r <= a_nxt;
      b_r <= b_nxt;
      flags_r <= flags_nxt;
      opc_r <= opc_nxt;
      opHi_r <= opHi_nxt;
      opLo_r <= opLo_nxt;
      useY_r <= useY_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign opFetch = (state_r == ST_FETCH);
  assign firstAccumulator = a_r;
  assign secondAccumulator = b_r;
  assign indexX = x_r;
  assign indexY = y_r;
  assign stackPtr = sp_r;
  assign progCnt = pc_r;
  assign conditionCodeByte = flags_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_byteResult;
    execByte && ce && !presetEn && !opc_r[6] |=> firstAccumulator == $past(diffByte);
  endproperty
  a_byteResult: assert property (p_byteResult) else $error("byte subtract result wrong"); // RULE1
  property p_negFlag;
    (execByte || execWord) && ce && !presetEn |=> conditionCodeByte[FLAG_N] == (isWord ? double_accumulator[15] : selAcc[7]);
  endproperty
  a_negFlag: assert property (p_negFlag) else $error("negative flag mismatch"); // RULE2
  property p_byteOvf;
    execByte && ce && !presetEn && !opc_r[6] |=> conditionCodeByte[FLAG_V] ==
      (($past(a_r[7]) != $past(busDataIn[7])) && (a_r[7] != $past(a_r[7])));
  endproperty
  a_byteOvf: assert property (p_byteOvf) else $error("byte overflow flag mismatch"); // RULE3
  property p_byteBorrow;
    execByte && ce && !presetEn |=> conditionCodeByte[FLAG_C] == ($past(selAcc) < $past(busDataIn));
  endproperty
  a_byteBorrow: assert property (p_byteBorrow) else $error("byte borrow flag mismatch"); // RULE4
  property p_wordResult;
    execWord && ce && !presetEn |=> {firstAccumulator, secondAccumulator} == $past(diffWord)
      && conditionCodeByte[FLAG_C] == ($past(double_accumulator) < $past(operWord));
  endproperty
  a_wordResult: assert property (p_wordResult) else $error("word subtract wrong"); // RULE8
  property p_dummyRead;
    (state_r == ST_IDXDUM || state_r == ST_TAILDUM) |-> busAddr == DUMMY_ADDR && busRw;
  endproperty
  a_dummyRead: assert property (p_dummyRead) else $error("dummy cycle not at FFFF"); // RULE5
  property p_pushStep;
    state_r == ST_PUSH && ce && !presetEn |=> stackPtr == $past(stackPtr) - 16'h0001;
  endproperty
  a_pushStep: assert property (p_pushStep) else $error("stack pointer not decremented"); // RULE12
  property p_trapLength;
    opFetch && ce && !presetEn && busDataIn == OPC_TRAP ##1 (ce && !presetEn)[*8] ##1 (ce && !presetEn)[*5]
      |=> opFetch && busAddr == progCnt;
  endproperty
  a_trapLength: assert property (p_trapLength) else $error("trap not 14 cycles"); // RULE16
  property p_maskSet;
    state_r == ST_TRAPRPT && ce && !presetEn |=> state_r == ST_VECHI &&
      conditionCodeByte == ($past(conditionCodeByte) | (8'h01 << FLAG_I));
  endproperty
  a_maskSet: assert property (p_maskSet) else $error("mask not set after stacking"); // RULE13
  c_trap: cover property (state_r == ST_VECLO && ce);
  c_word: cover property (execWord && ce && useY_r);
  c_byteB: cover property (execByte && ce && opc_r[6]);
endmodule // cpu_subtract_and_soft_trap

/* File: bus_memory.sv */
`timescale 1ns/100ps
module bus_memory (
  input wire logic clk,
  input wire logic ce,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busDataOut,
  input wire logic busRw,
  output logic [7:0] busDataIn
);
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h01;
    end
  end

  // Zero-wait read; while the core writes, the line shows a moving pattern rather than stale data
  assign busDataIn = busRw ? mem[busAddr] : (busAddr[7:0] ^ 8'h5A);

  always @(posedge clk) begin
    if (ce && !busRw) begin
      mem[busAddr] <= busDataOut;
    end
  end
endmodule // bus_memory

/* File: cpu_subtract_and_soft_trap_test.sv */
`timescale 1ns/100ps
module cpu_subtract_and_soft_trap_test import cpu_sub_trap_pkg::*;;
  logic clk = 1'b0;
  logic rst_n, ce, presetEn;
  logic [15:0] presetPc, presetX, presetY, presetSp, busAddr, indexX, indexY, stackPtr, progCnt, lastAddr;
  logic [7:0] presetA, presetB, presetFlags, busDataIn, busDataOut, firstAccumulator, secondAccumulator;
  logic [7:0] conditionCodeByte;
  logic busRw, opFetch;
  // Lets one trap run without stalls so the cycle-exact trap property is exercised
  logic noStall = 1'b0;
  logic [31:0] seed = 32'h0000_6bf9;
  int nErrors = 0;
  int testsRun = 0;

  always #25 clk = ~clk;

  cpu_subtract_and_soft_trap i_cpu_subtract_and_soft_trap (.clk(clk), .rst_n(rst_n), .ce(ce), .presetEn(presetEn),
    .presetPc(presetPc), .presetX(presetX), .presetY(presetY), .presetSp(presetSp), .presetA(presetA),
    .presetB(presetB), .presetFlags(presetFlags), .busDataIn(busDataIn), .busAddr(busAddr), .busDataOut(busDataOut),
    .busRw(busRw), .opFetch(opFetch), .firstAccumulator(firstAccumulator), .secondAccumulator(secondAccumulator),
    .indexX(indexX), .indexY(indexY), .stackPtr(stackPtr), .progCnt(progCnt), .conditionCodeByte(conditionCodeByte));

  bus_memory i_bus_memory (.clk(clk), .ce(ce), .busAddr(busAddr), .busDataOut(busDataOut), .busRw(busRw),
    .busDataIn(busDataIn));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [3:0] subFlags(input logic x7, input logic m7, input logic r7, input logic zero);
    return {r7, zero, (x7 & ~m7 & ~r7) | (~x7 & m7 & r7), (~x7 & m7) | (m7 & r7) | (r7 & ~x7)};
  endfunction

  task automatic rnd();
    seed = lfsrNext(seed);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    if (nErrors == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic put(inout logic [15:0] a, input logic [7:0] v);
    i_bus_memory.mem[a] = v;
    a = a + 16'h0001;
  endtask

  task automatic preset(input logic [15:0] pc, input logic [15:0] xv, input logic [15:0] yv,
                        input logic [15:0] dv, input logic [7:0] cc);
    @(negedge clk);
    presetPc = pc;
    presetX = xv;
    presetY = yv;
    presetSp = 16'h01F0;
    presetA = dv[15:8];
    presetB = dv[7:0];
    presetFlags = cc;
    ce = 1'b1;
    presetEn = 1'b1;
  endtask

  // Counts enabled cycles up to the next opcode fetch; random stalls keep the freeze path busy
  task automatic runInstr(output int cyc);
    cyc = 0;
    for (int k = 0; k < 80; k++) begin
      @(negedge clk);
      presetEn = 1'b0;
      if (opFetch === 1'b1 && cyc > 0) break;
      rnd();
      ce = noStall || (seed[1:0] != 2'b00);
      if (ce) lastAddr = busAddr;
      @(posedge clk);
      if (ce) cyc++;
    end
    ce = 1'b1;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic doSub(input logic useB, input logic word, input logic [2:0] m, input logic [15:0] d,
                       input logic [15:0] opnd);
    logic [15:0] p, ea, xv, yv, r;
    logic [7:0] cc, opc, ff, xb, rb;
    logic [3:0] fl;
    int cyc;
    rnd();
    cc = seed[7:0];
    xv = {8'h30, seed[15:8]};
    yv = {8'h40, seed[23:16]};
    ff = seed[31:24];
    opc = (word ? 8'h83 : (useB ? 8'hC0 : 8'h80)) | {2'b00, (m == 3'd4) ? 2'h2 : m[1:0], 4'h0};
    case (m)
      3'd1: ea = {9'h000, ff[6:0]} | 16'h0010;
      3'd2: ea = xv + {8'h00, ff};
      3'd3: ea = {8'h20, ff};
      default: ea = yv + {8'h00, ff};
    endcase
    p = 16'h0100;
    if (m == 3'd4) put(p, OPC_PREFIX_Y);
    put(p, opc);
    if (m == 3'd0 && word) put(p, opnd[15:8]);
    if (m == 3'd0) put(p, opnd[7:0]);
    if (m == 3'd1) put(p, ea[7:0]);
    if (m == 3'd3) put(p, ea[15:8]);
    if (m == 3'd3) put(p, ea[7:0]);
    if (m == 3'd2 || m == 3'd4) put(p, ff);
    if (m != 3'd0) i_bus_memory.mem[ea] = word ? opnd[15:8] : opnd[7:0];
    if (m != 3'd0 && word) i_bus_memory.mem[ea + 16'h0001] = opnd[7:0];
    preset(16'h0100, xv, yv, d, cc);
    runInstr(cyc);
    if (word) begin
      r = d - opnd;
      fl = subFlags(d[15], opnd[15], r[15], r == 16'h0000);
      check({firstAccumulator, secondAccumulator}, r);
      check(lastAddr, DUMMY_ADDR);
    end else begin
      xb = useB ? d[7:0] : d[15:8];
      rb = xb - opnd[7:0];
      fl = subFlags(xb[7], opnd[7], rb[7], rb == 8'h00);
      check({firstAccumulator, secondAccumulator}, useB ? {d[15:8], rb} : {rb, d[7:0]});
    end
    check({8'h00, conditionCodeByte}, {8'h00, cc[7:4], fl});
    check(progCnt, p);
    check(indexX, xv);
    check(indexY, yv);
    check(16'(cyc), 16'((m == 3'd0 ? 2 : m == 3'd1 ? 3 : m == 3'd4 ? 5 : 4) + (word ? 2 : 0)));
  endtask

  task automatic doTrap(input logic maskOn);
    logic [15:0] p, vec, xv, yv, dv;
    logic [7:0] cc;
    logic [7:0] st [9];
    int cyc;
    rnd();
    xv = seed[31:16];
    yv = seed[15:0];
    rnd();
    dv = seed[15:0];
    cc = maskOn ? (seed[23:16] | 8'h10) : (seed[23:16] & 8'hEF);
    vec = {8'h50, seed[31:24]};
    p = 16'h0123;
    put(p, OPC_TRAP);
    i_bus_memory.mem[TRAP_VECTOR] = vec[15:8];
    i_bus_memory.mem[TRAP_VECTOR + 16'h0001] = vec[7:0];
    st = '{8'h24, 8'h01, yv[7:0], yv[15:8], xv[7:0], xv[15:8], dv[15:8], dv[7:0], cc};
    preset(16'h0123, xv, yv, dv, cc);
    runInstr(cyc);
    check(16'(cyc), 16'h000E);
    for (int k = 0; k < 9; k++) begin
      check({8'h00, i_bus_memory.mem[16'h01F0 - 16'(k)]}, {8'h00, st[k]});
    end
    check(stackPtr, 16'h01E7);
    check({8'h00, conditionCodeByte}, {8'h00, cc | 8'h10});
    check(progCnt, vec);
    check(lastAddr, TRAP_VECTOR + 16'h0001);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    presetEn = 1'b0;
    {presetPc, presetX, presetY, presetSp} = '0;
    {presetA, presetB, presetFlags} = '0;
    lastAddr = 16'h0000;
    repeat (20) @(posedge clk);
    check(stackPtr, SP_RESET);
    check({8'h00, conditionCodeByte}, {8'h00, FLAGS_RESET});
    @(negedge clk);
    rst_n = 1'b1;
    doSub(1'b0, 1'b0, 3'd1, 16'h8000, 16'h0001);
    doSub(1'b1, 1'b0, 3'd0, 16'h0000, 16'h0001);
    doSub(1'b0, 1'b1, 3'd0, 16'h1234, 16'h1234);
    doSub(1'b0, 1'b1, 3'd3, 16'h8000, 16'h0001);
    for (int rep = 0; rep < 3; rep++) begin
      for (int k = 0; k < 15; k++) begin
        rnd();
        doSub(k[0] & (k < 10), k >= 10, 3'(k % 5), seed[15:0], seed[31:16]);
      end
      noStall = (rep == 0);
      doTrap(rep[0]);
      noStall = 1'b0;
    end
    testDone();
  end

  initial begin
    #2_000_000;
    nErrors++;
    testDone();
  end
endmodule // cpu_subtract_and_soft_trap_test
